// ==== hdl/i2cra_pkg.sv ====
// Notes on behaviour
// - two-wire slave only when strap low
// - clock from shared pin, data open-drain
// - address 54h select low, 55h high
// - unused serial output left undriven
// - data changes only while clock low
// - start and stop from data edges
// - bus busy from start until stop
// - repeated start acts like first start
// - eight bits msb first plus ack
// - receiver pulls data low on ninth
// - addressed receiver acknowledges every byte
// - first byte address plus direction bit
// - write: index byte then data byte
// - register updates at final ack edge
// - master sets index before read
// - consecutive bytes autoincrement the index
package i2cra_pkg;
    localparam logic [6:0] I2CRA_ADDR_LO = 7'h54;
    localparam logic [6:0] I2CRA_ADDR_HI = 7'h55;
    localparam logic I2CRA_DIR_WRITE = 1'b0;
    localparam logic I2CRA_DIR_READ = 1'b1;
    localparam logic I2CRA_STRAP_TWO_WIRE = 1'b0;
    localparam int I2CRA_BITS = 8;
    localparam logic [3:0] I2CRA_ACK_BIT = 4'h8;
    localparam int I2CRA_REGS = 16;
    localparam int I2CRA_IDX_W = 4;
    localparam logic [7:0] I2CRA_REG_RST = 8'h00;
    // master side: 125 MHz / (4*(I2CRA_QTR_CNT+1)) gives the bus clock
    localparam int I2CRA_CLK_HZ = 125000000;
    localparam int I2CRA_SCL_HZ = 400000;
    localparam int I2CRA_HALF = I2CRA_CLK_HZ / (2 * I2CRA_SCL_HZ);
    localparam int I2CRA_QTR = I2CRA_HALF / 2;
    localparam logic [7:0] I2CRA_HALF_CNT = 8'(I2CRA_HALF - 1);
    localparam logic [7:0] I2CRA_QTR_CNT = 8'(I2CRA_QTR);
endpackage

// ==== hdl/i2cra_if.sv ====
`timescale 1ns/100ps
interface i2cra_if;
    logic scl_o;
    logic scl_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda_mst_o;
    logic sda_mst_oe;
    logic so_o;
    logic so_oe;
    logic scl_i;
    logic sda_i;
    modport dev (
        input scl_i,
        input sda_i,
        output sda_dev_o,
        output sda_dev_oe,
        output so_o,
        output so_oe
    );
    modport mst (
        input scl_i,
        input sda_i,
        output scl_o,
        output scl_oe,
        output sda_mst_o,
        output sda_mst_oe
    );
endinterface

// ==== hdl/i2cra_slave.sv ====
`timescale 1ns/100ps
module i2cra_slave import i2cra_pkg::*; (
    input wire logic sys_clk,
    input wire logic rstn,
    i2cra_if.dev bus,
    input wire logic if_sel,
    input wire logic addr_sel,
    input wire logic [I2CRA_IDX_W-1:0] peek_idx,
    output logic [7:0] peek_data,
    output logic bus_busy,
    output logic reg_wr_pulse
);
    // ************************************************
    // pin synchronisers
    // ************************************************
    logic [1:0] scl_s, sda_s, sel_s, asel_s;
    logic scl_q, sda_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            scl_s <= 2'b11;
            sda_s <= 2'b11;
            sel_s <= 2'b11;
            asel_s <= 2'b00;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_s <= {scl_s[0], bus.scl_i};
            sda_s <= {sda_s[0], bus.sda_i};
            sel_s <= {sel_s[0], if_sel};
            asel_s <= {asel_s[0], addr_sel};
            scl_q <= scl_s[1];
            sda_q <= sda_s[1];
        end
    end
    wire active = (sel_s[1] == I2CRA_STRAP_TWO_WIRE);
    wire scl = scl_s[1];
    wire sda = sda_s[1];
    wire scl_rise = active && scl && !scl_q;
    wire scl_fall = active && !scl && scl_q;
    wire start_ev = active && scl && scl_q && sda_q && !sda;
    wire stop_ev = active && scl && scl_q && !sda_q && sda;
    wire [6:0] my_addr = asel_s[1] ? I2CRA_ADDR_HI : I2CRA_ADDR_LO;

    // ************************************************
    // byte engine
    // ************************************************
    typedef enum logic [2:0] {
        I2CRA_IDLE, I2CRA_ADDR, I2CRA_INDEX, I2CRA_WDATA, I2CRA_RDATA,
        I2CRA_SKIP
    } i2cra_state_t;
    i2cra_state_t state;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic [7:0] txb;
    logic ack_phase;
    logic reading;
    logic [I2CRA_IDX_W-1:0] idx;
    logic [7:0] regs [I2CRA_REGS];
    logic sda_low;

    wire [7:0] rx_byte = {shreg[6:0], sda};
    wire last_bit = (bitn == 4'(I2CRA_BITS - 1));
    // looked at on the fall after bit 0, when the whole byte is in shreg
    wire addr_hit = (shreg[7:1] == my_addr);
    wire in_ack = (bitn == I2CRA_ACK_BIT);
    // ack bits of write bytes are driven by us; read acks come from master
    wire give_ack = (state == I2CRA_ADDR && addr_hit) ||
        state == I2CRA_INDEX || state == I2CRA_WDATA;
    wire master_nack = in_ack && reading && sda;
    wire [I2CRA_IDX_W-1:0] idx_inc = idx + 1'b1;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state <= I2CRA_IDLE;
            bitn <= 4'h0;
            shreg <= 8'h00;
            txb <= 8'h00;
            ack_phase <= 1'b0;
            reading <= 1'b0;
            idx <= '0;
            sda_low <= 1'b0;
            bus_busy <= 1'b0;
            reg_wr_pulse <= 1'b0;
            peek_data <= I2CRA_REG_RST;
            for (int i = 0; i < I2CRA_REGS; i++) begin
                regs[i] <= I2CRA_REG_RST;
            end
        end else begin
            reg_wr_pulse <= 1'b0;
            if (!active) begin
                state <= I2CRA_IDLE;
                sda_low <= 1'b0;
                bus_busy <= 1'b0;
            end else if (start_ev) begin
                state <= I2CRA_ADDR;
                // the clock fall that closes a start precedes bit 7,
                // so it must wrap the count to zero, not advance it
                bitn <= 4'hf;
                reading <= 1'b0;
                sda_low <= 1'b0;
                bus_busy <= 1'b1;
            end else if (stop_ev) begin
                state <= I2CRA_IDLE;
                sda_low <= 1'b0;
                bus_busy <= 1'b0;
            end else if (state != I2CRA_IDLE && state != I2CRA_SKIP) begin
                if (scl_rise && !in_ack) begin
                    shreg <= rx_byte;
                end
                if (scl_rise && in_ack) begin
                    ack_phase <= 1'b0;
                    if (state == I2CRA_WDATA) begin
                        regs[idx] <= shreg;
                        idx <= idx_inc;
                        reg_wr_pulse <= 1'b1;
                    end
                    if (master_nack) begin
                        state <= I2CRA_SKIP;
                    end
                end
                if (scl_fall) begin
                    if (in_ack) begin
                        bitn <= 4'h0;
                        sda_low <= reading ? !txb[7] : 1'b0;
                        txb <= {txb[6:0], 1'b0};
                        if (!reading && state == I2CRA_ADDR) begin
                            state <= I2CRA_INDEX;
                        end else if (state == I2CRA_INDEX) begin
                            state <= I2CRA_WDATA;
                        end
                    end else if (last_bit) begin
                        bitn <= I2CRA_ACK_BIT;
                        ack_phase <= 1'b1;
                        if (state == I2CRA_ADDR && !addr_hit) begin
                            state <= I2CRA_SKIP;
                            sda_low <= 1'b0;
                        end else if (state == I2CRA_ADDR &&
                            shreg[0] == I2CRA_DIR_READ) begin
                            state <= I2CRA_RDATA;
                            reading <= 1'b1;
                            sda_low <= 1'b1;
                            txb <= regs[idx];
                            idx <= idx_inc;
                        end else if (reading) begin
                            sda_low <= 1'b0;
                            txb <= regs[idx];
                            idx <= idx_inc;
                        end else begin
                            sda_low <= give_ack;
                            if (state == I2CRA_INDEX) begin
                                idx <= shreg[I2CRA_IDX_W-1:0];
                            end
                        end
                    end else begin
                        bitn <= bitn + 4'h1;
                        sda_low <= reading ? !txb[7] : 1'b0;
                        txb <= {txb[6:0], 1'b0};
                    end
                end
            end
            peek_data <= regs[peek_idx];
        end
    end

    // ************************************************
    // pins: open-drain data, serial output never driven
    // ************************************************
    assign bus.sda_dev_o = 1'b0;
    assign bus.sda_dev_oe = sda_low;
    assign bus.so_o = 1'b0;
    assign bus.so_oe = 1'b0;
endmodule

// ==== hdl/i2cra_master.sv ====
`timescale 1ns/100ps
module i2cra_master import i2cra_pkg::*; (
    input wire logic sys_clk,
    input wire logic rstn,
    i2cra_if.mst bus,
    input wire logic req,
    input wire logic rd,
    input wire logic [6:0] dev_addr,
    input wire logic [7:0] reg_idx,
    input wire logic [7:0] wdata,
    output logic busy,
    output logic done,
    output logic nacked,
    output logic [7:0] rdata
);
    // simple single-register write or read (write index, rs, read one)
    typedef enum logic [2:0] {
        I2CRA_M_IDLE, I2CRA_M_START, I2CRA_M_BYTE, I2CRA_M_STOP
    } i2cra_mstate_t;
    i2cra_mstate_t st;
    logic [7:0] cnt;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [1:0] bidx;
    logic [7:0] sh;
    logic scl_drv_low, sda_drv_low, rd_q, rs_done;
    logic [1:0] sda_s;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sda_s <= 2'b11;
        end else begin
            sda_s <= {sda_s[0], bus.sda_i};
        end
    end
    wire tick = (cnt == I2CRA_QTR_CNT);
    wire last_byte = rd_q ? (rs_done) : (bidx == 2'd2);
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st <= I2CRA_M_IDLE;
            cnt <= 8'h00;
            ph <= 2'd0;
            bitn <= 4'h0;
            bidx <= 2'd0;
            sh <= 8'h00;
            scl_drv_low <= 1'b0;
            sda_drv_low <= 1'b0;
            rd_q <= 1'b0;
            rs_done <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            nacked <= 1'b0;
            rdata <= 8'h00;
        end else begin
            done <= 1'b0;
            cnt <= tick ? 8'h00 : cnt + 8'h01;
            if (st == I2CRA_M_IDLE) begin
                if (req) begin
                    st <= I2CRA_M_START;
                    rd_q <= rd;
                    rs_done <= 1'b0;
                    bidx <= 2'd0;
                    busy <= 1'b1;
                    nacked <= 1'b0;
                    ph <= 2'd0;
                    cnt <= 8'h00;
                end
            end else if (tick) begin
                ph <= ph + 2'd1;
                case (st)
                I2CRA_M_START: begin
                    case (ph)
                    2'd0: scl_drv_low <= 1'b0;
                    2'd1: sda_drv_low <= 1'b0;
                    2'd2: sda_drv_low <= 1'b1;
                    default: begin
                        scl_drv_low <= 1'b1;
                        st <= I2CRA_M_BYTE;
                        bitn <= 4'h0;
                        sh <= {dev_addr, rs_done};
                    end
                    endcase
                end
                I2CRA_M_BYTE: begin
                    case (ph)
                    2'd0: begin
                        if (bitn == I2CRA_ACK_BIT) begin
                            sda_drv_low <= rs_done && !last_byte;
                        end else if (rs_done && bidx == 2'd1) begin
                            sda_drv_low <= 1'b0;
                        end else begin
                            sda_drv_low <= !sh[7];
                        end
                    end
                    2'd1: scl_drv_low <= 1'b0;
                    2'd2: begin
                        if (bitn == I2CRA_ACK_BIT &&
                            (!rs_done || bidx == 2'd0)) begin
                            nacked <= nacked | sda_s[1];
                        end
                        if (bitn != I2CRA_ACK_BIT) begin
                            sh <= {sh[6:0], sda_s[1]};
                        end
                    end
                    default: begin
                        scl_drv_low <= 1'b1;
                        if (bitn != I2CRA_ACK_BIT) begin
                            bitn <= bitn + 4'h1;
                        end else begin
                            bitn <= 4'h0;
                            bidx <= bidx + 2'd1;
                            if (rs_done && bidx == 2'd1) begin
                                rdata <= sh;
                            end
                            if (rd_q && !rs_done && bidx == 2'd1) begin
                                st <= I2CRA_M_START;
                                rs_done <= 1'b1;
                                bidx <= 2'd0;
                                sda_drv_low <= 1'b0;
                            end else if ((last_byte && bidx != 2'd0) ||
                                nacked) begin
                                st <= I2CRA_M_STOP;
                            end
                            sh <= (bidx == 2'd0) ? reg_idx : wdata;
                        end
                    end
                    endcase
                end
                I2CRA_M_STOP: begin
                    case (ph)
                    2'd0: sda_drv_low <= 1'b1;
                    2'd1: scl_drv_low <= 1'b0;
                    2'd2: sda_drv_low <= 1'b0;
                    default: begin
                        st <= I2CRA_M_IDLE;
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                    endcase
                end
                default: st <= I2CRA_M_IDLE;
                endcase
            end
        end
    end
    assign bus.scl_o = 1'b0;
    assign bus.scl_oe = scl_drv_low;
    assign bus.sda_mst_o = 1'b0;
    assign bus.sda_mst_oe = sda_drv_low;
endmodule

// ==== test/i2cra_assertions.sv ====
`timescale 1ns/100ps
// ************************************************************
// wire checker beside the link between the two ends
// ************************************************************
module i2cra_assertions import i2cra_pkg::*; (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_dev_oe,
    input wire logic sda_mst_oe,
    input wire logic so_oe,
    input wire logic if_sel,
    input wire logic bus_busy,
    input wire logic reg_wr_pulse
);
    logic scl_q;
    logic sda_q;
    logic first_byte;
    logic [3:0] bitn;
    logic [7:0] shift;
    wire start_seen = scl_i & scl_q & sda_q & ~sda_i;
    wire scl_rise = scl_i & ~scl_q;
    wire addr_foreign = (shift[7:1] != I2CRA_ADDR_LO)
        && (shift[7:1] != I2CRA_ADDR_HI);

    // bit slot within the byte; 9 is the acknowledge slot
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            first_byte <= 1'b0;
            bitn <= 4'h0;
            shift <= 8'h00;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            if (start_seen) begin
                bitn <= 4'h0;
                first_byte <= 1'b1;
            end else if (scl_rise) begin
                bitn <= (bitn == 4'h9) ? 4'h1 : bitn + 4'h1;
                if (bitn != 4'h8) shift <= {shift[6:0], sda_i};
                if (bitn == 4'h9) first_byte <= 1'b0;
            end
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_start;
        scl_i && $past(scl_i) && $fell(sda_i);
    endsequence
    sequence s_stop;
        scl_i && $past(scl_i) && $rose(sda_i);
    endsequence
    sequence s_ack_slot;
        bitn == 4'h9 && scl_i;
    endsequence

    a_so_pin_idle: assert property (!so_oe)
        else $error("serial output driven in two-wire mode");
    a_dev_sda_stable: assert property (scl_i && $past(scl_i)
        |-> $stable(sda_dev_oe))
        else $error("device changed data while clock high");
    a_busy_after_start: assert property (s_start ##0 !if_sel
        |-> ##[1:4] bus_busy)
        else $error("start not seen as busy");
    a_idle_after_stop: assert property (s_stop |-> ##[1:4] !bus_busy)
        else $error("stop not seen as idle");
    a_busy_holds: assert property (bus_busy && !scl_i |=> bus_busy)
        else $error("busy dropped without a stop");
    a_wr_at_ack: assert property (reg_wr_pulse
        |-> s_ack_slot ##0 sda_dev_oe)
        else $error("store outside the device acknowledge");
    a_mst_release_ack: assert property (s_ack_slot ##0 sda_dev_oe
        |-> !sda_mst_oe)
        else $error("transmitter held data in acknowledge");
    a_ack_held: assert property (s_ack_slot ##0 $past(scl_i)
        ##0 $past(sda_dev_oe) |-> sda_dev_oe)
        else $error("acknowledge released during clock high");
    a_no_ack_foreign: assert property (s_ack_slot ##0 first_byte
        ##0 addr_foreign |-> !sda_dev_oe)
        else $error("foreign address acknowledged");
endmodule

// ==== test/i2c_register_access_slave_test.sv ====
`timescale 1ns/100ps
module i2c_register_access_slave_test import i2cra_pkg::*;;
    logic sys_clk;
    logic rstn;
    logic if_sel;
    logic addr_sel;
    logic [I2CRA_IDX_W-1:0] peek_idx;
    logic [7:0] peek_data;
    logic bus_busy;
    logic reg_wr_pulse;
    logic req;
    logic rd;
    logic [6:0] dev_addr;
    logic [7:0] reg_idx;
    logic [7:0] wdata;
    logic busy;
    logic done;
    logic nacked;
    logic [7:0] rdata;
    int failures = 0;
    int total_checks = 0;
    int wr_count = 0;

    // ************************************************************
    // link: wired-and with pull-ups
    // ************************************************************
    i2cra_if bus();
    assign bus.scl_i = ~bus.scl_oe;
    assign bus.sda_i = ~(bus.sda_dev_oe | bus.sda_mst_oe);

    i2cra_slave i2cra_slave_inst (.sys_clk(sys_clk), .rstn(rstn),
        .bus(bus), .if_sel(if_sel), .addr_sel(addr_sel),
        .peek_idx(peek_idx), .peek_data(peek_data),
        .bus_busy(bus_busy), .reg_wr_pulse(reg_wr_pulse));
    i2cra_master i2cra_master_inst (.sys_clk(sys_clk), .rstn(rstn),
        .bus(bus), .req(req), .rd(rd), .dev_addr(dev_addr),
        .reg_idx(reg_idx), .wdata(wdata), .busy(busy), .done(done),
        .nacked(nacked), .rdata(rdata));
    i2cra_assertions chk_inst (.sys_clk(sys_clk), .rstn(rstn),
        .scl_i(bus.scl_i), .sda_i(bus.sda_i),
        .sda_dev_oe(bus.sda_dev_oe), .sda_mst_oe(bus.sda_mst_oe),
        .so_oe(bus.so_oe), .if_sel(if_sel), .bus_busy(bus_busy),
        .reg_wr_pulse(reg_wr_pulse));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (reg_wr_pulse === 1'b1) wr_count++;
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
        input string what);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one whole master transaction; read sets the index first
    task automatic xfer(input logic r, input logic [6:0] a,
        input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        rd <= r;
        dev_addr <= a;
        reg_idx <= idx;
        wdata <= d;
        req <= 1'b1;
        @(posedge sys_clk);
        req <= 1'b0;
        @(negedge sys_clk);
        while (done !== 1'b1 && n < 40000) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 40000) begin
            failures++;
            $display("ERROR %0t transfer timed out", $time);
            summarize();
        end
    endtask

    task automatic peek(input logic [3:0] idx, input logic [7:0] exp);
        @(posedge sys_clk);
        peek_idx <= idx;
        repeat (2) @(negedge sys_clk);
        check(peek_data, exp, "register content");
    endtask

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        rstn = 1'b0;
        if_sel = I2CRA_STRAP_TWO_WIRE;
        addr_sel = 1'b0;
        peek_idx = 4'h0;
        req = 1'b0;
        rd = 1'b0;
        dev_addr = 7'h00;
        reg_idx = 8'h00;
        wdata = 8'h00;
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        peek(4'h3, I2CRA_REG_RST);
        xfer(I2CRA_DIR_WRITE, I2CRA_ADDR_LO, 8'h03, 8'ha5);
        check({7'h00, nacked}, 8'h00, "write not acknowledged");
        check({6'h00, busy, bus_busy}, 8'h00, "bus left busy");
        peek(4'h3, 8'ha5);
        check(8'(wr_count), 8'h01, "store pulses");
        $display("test write done");
        xfer(I2CRA_DIR_READ, I2CRA_ADDR_LO, 8'h03, 8'h00);
        check(rdata, 8'ha5, "read data");
        check(8'(wr_count), 8'h01, "read stored data");
        $display("test read done");
        @(posedge sys_clk);
        addr_sel <= 1'b1;
        xfer(I2CRA_DIR_WRITE, I2CRA_ADDR_HI, 8'h1f, 8'h3c);
        peek(4'hf, 8'h3c);
        xfer(I2CRA_DIR_WRITE, I2CRA_ADDR_LO, 8'h03, 8'h11);
        check({7'h00, nacked}, 8'h01, "wrong address acked");
        xfer(I2CRA_DIR_WRITE, 7'h2a, 8'h03, 8'h22);
        check({7'h00, nacked}, 8'h01, "foreign address acked");
        peek(4'h3, 8'ha5);
        $display("test address select done");
        @(posedge sys_clk);
        if_sel <= ~I2CRA_STRAP_TWO_WIRE;
        xfer(I2CRA_DIR_WRITE, I2CRA_ADDR_HI, 8'h03, 8'h33);
        check({7'h00, nacked}, 8'h01, "deselected port acked");
        peek(4'h3, 8'ha5);
        @(posedge sys_clk);
        if_sel <= I2CRA_STRAP_TWO_WIRE;
        xfer(I2CRA_DIR_WRITE, I2CRA_ADDR_HI, 8'h00, 8'hff);
        peek(4'h0, 8'hff);
        check(8'(wr_count), 8'h03, "store pulses");
        $display("test strap done");
        summarize();
    end
endmodule
